// ==== include/scd_pkg.sv ====
package scd_pkg;
    localparam int FS_W = 10;
    localparam int RES_W = 24;
    localparam int CNT_W = 22;
    localparam int ORD_W = 3;
    localparam int NUM_STAGES = 4;
    // log2 of the largest decimation, 1024 * 1023 < 2**20
    localparam int DEC_LOG2 = 20;
    localparam int CIC_W = NUM_STAGES * DEC_LOG2 + 1;
    localparam int TOP4 = CIC_W - 1;
    localparam int TOP3 = 3 * DEC_LOG2;
    localparam int DEC_BASE_DEF = 1024;
    localparam logic [FS_W-1:0] FS_OFF = 10'h000;
    localparam logic [ORD_W-1:0] ORDER3 = 3'h3;
    localparam logic [ORD_W-1:0] ORDER4 = 3'h4;
    localparam logic [ORD_W-1:0] ORD_ZERO = 3'h0;
    localparam logic [ORD_W-1:0] ORD_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 22'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 22'h000001;
    // sixty hertz window is 5/6 of a fifty hertz decimation window
    localparam int NOTCH_NUM = 5;
    localparam int NOTCH_DEN = 6;
    localparam int FIFO_DEPTH = 16;
    localparam logic [RES_W-1:0] RES_ZERO = 24'h000000;

    typedef enum logic [1:0] {
        SCD_IDLE = 2'b00,
        SCD_SETTLE = 2'b01,
        SCD_RUN = 2'b11
    } scd_state_t;
endpackage

// ==== src/scd_fifo.sv ====
`timescale 1ns/10ps
module scd_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // filling side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // draining side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;
    wire logic push;
    wire logic pop;

    assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign push = i_in_valid && o_in_ready;
    // head word moves into the output register when it is free
    assign pop = (cnt_r != '0) && (!out_valid_r || i_out_ready);
    assign o_out_valid = out_valid_r;
    assign o_out_data = out_data_r;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
                out_data_r <= mem_r[rd_ptr_r];
                out_valid_r <= 1'b1;
            end else if (i_out_ready) begin
                out_valid_r <= 1'b0;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== src/scd_sinc_chop_timing.sv ====
`timescale 1ns/10ps
// What this block does
// RULE1 - chop with fourth order: result every 4*1024*rate word clocks, twice that with zero latency, word 1..1023
// RULE2 - chop with third order: result every 3*1024*rate word clocks, twice that with zero latency, word 1..1023
// RULE3 - chop swaps input polarity each conversion, averaging successive settled conversions
// RULE4 - chopped settling time is two output periods for either order, one period with zero latency
// RULE5 - channel change resets modulator and filter, full settle, then every period
// RULE6 - single channel keeps converting at programmed rate after input steps
// RULE7 - chop averaging puts nulls at odd multiples of half output rate
// RULE8 - sixty hertz notch bit adds 60 Hz null, output rate unchanged
// RULE9 - non-chop third order: rate word 480 gives 10 Hz, zero latency thirds it
// RULE10 - host uses chopped third order only up to 320 Hz output rate
// RULE11 - zero latency mode gives every result the complete settling time
// RULE12 - select bit high picks third order sinc, else fourth order
// RULE13 - plain third order: result every 1024*rate word, settle three periods
// RULE14 - output is mean of last two opposite polarity conversions, inverted one negated
// RULE15 - rate word zero yields no result and no counting
module scd_sinc_chop_timing #(
    parameter int DEC_BASE = scd_pkg::DEC_BASE_DEF
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // configuration
    input wire logic [scd_pkg::FS_W-1:0] i_rate_select_word,
    input wire logic i_third_order_filter_select,
    input wire logic i_chop_enable,
    input wire logic i_zero_latency,
    input wire logic i_sixty_hz_notch_enable,
    input wire logic i_chan_change,
    // modulator side
    input wire logic i_mod_bit,
    output logic o_mod_reset,
    output logic o_chop_swap,
    // result stream
    output logic o_result_valid,
    input wire logic i_result_ready,
    output logic [scd_pkg::RES_W-1:0] o_result_data,
    // status
    output logic o_settling,
    output logic o_overrun
);
    import scd_pkg::*;

    function automatic logic [RES_W-1:0] scale_out(
        input logic [CIC_W-1:0] v,
        input logic o3
    );
        // full scale only at the top rate word; small words give small codes
        scale_out = o3 ? v[TOP3 -: RES_W] : v[TOP4 -: RES_W];
    endfunction

    scd_state_t state_r;
    scd_state_t state_nxt;
    logic [FS_W-1:0] fs_r;
    logic [3:0] mode_r;
    logic [CNT_W-1:0] dec_cnt_r;
    logic [ORD_W-1:0] dec_num_r;
    logic [ORD_W-1:0] valid_cnt_r;
    logic pol_r;
    logic have_prev_r;
    logic [RES_W-1:0] prev_r;
    logic [CIC_W-1:0] int_r [NUM_STAGES];
    logic [CIC_W-1:0] dly_r [NUM_STAGES];
    logic pend_r;
    logic [RES_W-1:0] pend_data_r;
    logic overrun_r;
    logic mod_reset_r;

    wire logic [3:0] mode_now;
    wire logic restart;
    wire logic active;
    wire logic order3;
    wire logic [ORD_W-1:0] order;
    wire logic [CNT_W-1:0] r_len;
    wire logic [CNT_W-1:0] notch_lim;
    wire logic gate;
    wire logic [CIC_W-1:0] in_word;
    wire logic tick;
    wire logic conv_end;
    wire logic per_conv;
    wire logic filt_clr;
    wire logic [CIC_W-1:0] comb_in [NUM_STAGES];
    wire logic [CIC_W-1:0] comb_out [NUM_STAGES];
    wire logic [RES_W-1:0] y_res;
    wire logic [RES_W-1:0] sample;
    wire logic [RES_W:0] sum;
    wire logic res_plain;
    wire logic res_zl;
    wire logic res_chop;
    wire logic res_fire;
    wire logic [RES_W-1:0] res_data;
    wire logic fifo_ready;
    wire logic push;

    assign mode_now = {i_third_order_filter_select, i_chop_enable,
                       i_zero_latency, i_sixty_hz_notch_enable};
    // any reconfiguration restarts the conversion like a channel change
    assign restart = i_chan_change || (mode_now != mode_r)
                     || (i_rate_select_word != fs_r); // [RULE5]
    assign active = (fs_r != FS_OFF); // [RULE15]
    assign order3 = mode_r[3];
    assign order = order3 ? ORDER3 : ORDER4; // [RULE12]
    assign r_len = CNT_W'(DEC_BASE) * CNT_W'(fs_r); // [RULE13]
    assign notch_lim = CNT_W'((32'(r_len) * 32'(NOTCH_NUM))
                              / 32'(NOTCH_DEN));
    // boxcar of 1/60 s inside each 1/50 s window; window length kept
    assign gate = !(mode_r[0] && (dec_cnt_r >= notch_lim)); // [RULE8]
    assign in_word = !gate ? '0 : (i_mod_bit ? CIC_W'(1) : '1);
    assign tick = active && (dec_cnt_r == r_len - CNT_ONE);
    // chop and zero latency take one conversion per order decimations
    assign conv_end = tick && (dec_num_r == order - ORD_ONE); // [RULE1] [RULE2]
    assign per_conv = mode_r[2] || mode_r[1]; // [RULE11]
    assign filt_clr = restart || (per_conv && conv_end);

    assign comb_in[0] = order3 ? int_r[2] : int_r[NUM_STAGES-1];
    assign comb_out[0] = order3 ? comb_in[0] : comb_in[0] - dly_r[0];
    genvar g;
    generate
        for (g = 1; g < NUM_STAGES; g++) begin : g_comb
            assign comb_in[g] = comb_out[g-1];
            assign comb_out[g] = comb_in[g] - dly_r[g];
        end
    endgenerate

    assign y_res = scale_out(comb_out[NUM_STAGES-1], order3);
    // inverted-polarity conversion is negated before averaging
    assign sample = pol_r ? (RES_ZERO - y_res) : y_res; // [RULE14]
    assign sum = {sample[RES_W-1], sample} + {prev_r[RES_W-1], prev_r};
    // non-chop continuous: first result after order periods, then each
    assign res_plain = !per_conv && tick
                       && (valid_cnt_r == order - ORD_ONE); // [RULE13]
    assign res_zl = !mode_r[2] && mode_r[1] && conv_end; // [RULE9] [RULE11]
    // first chopped result needs two conversions, then one per conversion, or one per two with zero latency
    assign res_chop = mode_r[2] && conv_end && have_prev_r; // [RULE3] [RULE4]
    assign res_fire = !restart && (res_plain || res_zl || res_chop); // [RULE6]
    assign res_data = mode_r[2] ? sum[RES_W:1] : y_res; // [RULE7] [RULE14]
    assign push = pend_r && fifo_ready;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SCD_IDLE: begin
                if (active) begin
                    state_nxt = SCD_SETTLE;
                end
            end
            SCD_SETTLE: begin
                if (res_fire) begin
                    state_nxt = SCD_RUN;
                end
            end
            SCD_RUN: begin
                state_nxt = SCD_RUN;
            end
            default: begin
                state_nxt = SCD_IDLE;
            end
        endcase
        if (restart || !active) begin
            state_nxt = SCD_IDLE; // [RULE5] [RULE15]
        end
    end

    generate
        for (g = 0; g < NUM_STAGES; g++) begin : g_stage
            always_ff @(posedge i_sys_clk) begin
                if (!i_nrst || filt_clr) begin
                    int_r[g] <= '0;
                    dly_r[g] <= '0;
                end else if (active) begin
                    int_r[g] <= int_r[g]
                                + ((g == 0) ? in_word : int_r[(g == 0) ? 0 : g-1]);
                    if (tick) begin
                        dly_r[g] <= comb_in[g];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || restart || !active) begin
            dec_cnt_r <= CNT_ZERO;
            dec_num_r <= ORD_ZERO;
            valid_cnt_r <= ORD_ZERO;
        end else begin
            dec_cnt_r <= tick ? CNT_ZERO : dec_cnt_r + CNT_ONE;
            if (tick) begin
                dec_num_r <= conv_end ? ORD_ZERO : dec_num_r + ORD_ONE;
                if (valid_cnt_r != order - ORD_ONE) begin
                    valid_cnt_r <= valid_cnt_r + ORD_ONE;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || restart) begin
            pol_r <= 1'b0;
            have_prev_r <= 1'b0;
            prev_r <= RES_ZERO;
        end else if (mode_r[2] && conv_end) begin
            pol_r <= !pol_r; // [RULE3]
            prev_r <= sample;
            // zero latency pairs disjoint conversions, so no stale half
            have_prev_r <= !(mode_r[1] && have_prev_r); // [RULE11]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state_r <= SCD_IDLE;
            fs_r <= FS_OFF;
            mode_r <= '0;
            pend_r <= 1'b0;
            pend_data_r <= RES_ZERO;
            overrun_r <= 1'b0;
            mod_reset_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fs_r <= i_rate_select_word;
            mode_r <= mode_now;
            mod_reset_r <= restart; // [RULE5]
            if (res_fire) begin
                pend_r <= 1'b1;
                pend_data_r <= res_data;
            end else if (push) begin
                pend_r <= 1'b0;
            end
            // a stalled consumer loses the older result, flagged here
            if (restart) begin
                overrun_r <= 1'b0;
            end else if (res_fire && pend_r && !push) begin
                overrun_r <= 1'b1;
            end
        end
    end

    scd_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_in_valid(pend_r),
        .o_in_ready(fifo_ready),
        .i_in_data(pend_data_r),
        .o_out_valid(o_result_valid),
        .i_out_ready(i_result_ready),
        .o_out_data(o_result_data)
    );

    assign o_mod_reset = mod_reset_r;
    assign o_chop_swap = pol_r;
    assign o_settling = (state_r == SCD_SETTLE);
    assign o_overrun = overrun_r;
endmodule

// ==== test/scd_timing_chk_asserts.sv ====
`timescale 1ns/10ps
module scd_timing_chk
    import scd_pkg::*;
#(
    parameter int DEC_BASE = DEC_BASE_DEF
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // configuration
    input wire logic [scd_pkg::FS_W-1:0] i_rate_select_word,
    input wire logic i_third_order_filter_select,
    input wire logic i_chop_enable,
    input wire logic i_zero_latency,
    input wire logic i_sixty_hz_notch_enable,
    input wire logic i_chan_change,
    // converter side
    input wire logic o_mod_reset,
    input wire logic o_chop_swap,
    input wire logic o_result_valid,
    input wire logic i_result_ready,
    input wire logic [scd_pkg::RES_W-1:0] o_result_data,
    input wire logic o_settling,
    input wire logic o_overrun
);
    logic [13:0] cfg;
    logic [13:0] cfg_r;
    logic swap_r;
    logic armed_r;
    logic rise;
    int cnt_r;
    int per;
    assign cfg = {i_rate_select_word, i_third_order_filter_select,
                  i_chop_enable, i_zero_latency, i_sixty_hz_notch_enable};
    assign rise = o_chop_swap && !swap_r;
    // one conversion per polarity between two rising swaps
    assign per = 2 * (i_third_order_filter_select ? 3 : 4) * DEC_BASE
                 * int'(i_rate_select_word);
    always_ff @(posedge i_sys_clk) begin
        swap_r <= o_chop_swap;
        cfg_r <= cfg;
        cnt_r <= rise ? 1 : cnt_r + 1;
        // first rise after a restart only starts the count
        if (!i_nrst || i_chan_change || cfg != cfg_r || o_mod_reset) begin
            armed_r <= 1'b0;
        end else if (rise) begin
            armed_r <= 1'b1;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    AST_SWAP_PERIOD:
    assert property (rise && armed_r && cfg == cfg_r |-> cnt_r == per)
    else $error("polarity period wrong");
    AST_CHAN_MODRST:
    assert property (i_chan_change |-> ##[1:2] o_mod_reset)
    else $error("no modulator reset");
    AST_MODRST_PULSE:
    assert property (o_mod_reset |=> !o_mod_reset)
    else $error("modulator reset too long");
    AST_SETTLE_RISE:
    assert property (i_chan_change && i_rate_select_word != FS_OFF
                     |-> ##[1:3] o_settling)
    else $error("settling not raised");
    AST_SETTLE_END:
    assert property ($fell(o_settling) && i_result_ready && !o_mod_reset
                     |-> ##[1:4] o_result_valid)
    else $error("no result after settling");
    AST_NO_SWAP:
    assert property (!i_chop_enable && !$past(i_chop_enable)
                     && !$past(i_chop_enable, 2) |-> !o_chop_swap)
    else $error("swap without chop");
    AST_OVR_CLEAR:
    assert property (i_chan_change |-> ##[1:3] !o_overrun)
    else $error("overrun kept over restart");
    AST_HOLD:
    assert property (o_result_valid && !i_result_ready && !i_chan_change
                     |=> o_result_valid && $stable(o_result_data))
    else $error("result dropped while stalled");
    AST_OVR_CAUSE:
    assert property ($rose(o_overrun) |-> o_result_valid)
    else $error("overrun with empty queue");
endmodule

bind scd_sinc_chop_timing scd_timing_chk #(.DEC_BASE(DEC_BASE)) i_chk (
    .i_sys_clk, .i_nrst, .i_rate_select_word, .i_third_order_filter_select,
    .i_chop_enable, .i_zero_latency, .i_sixty_hz_notch_enable,
    .i_chan_change, .o_mod_reset, .o_chop_swap, .o_result_valid,
    .i_result_ready, .o_result_data, .o_settling, .o_overrun
);

// ==== test/scd_mod_model.sv ====
`timescale 1ns/10ps
module scd_mod_model (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // control from the converter
    input wire logic i_mod_reset,
    input wire logic i_chop_swap,
    // analog level stand-in
    input wire logic i_step,
    // bitstream
    output logic o_mod_bit
);
    logic [3:0] acc_r;
    logic [3:0] raw;
    logic [3:0] lvl;
    assign raw = i_step ? 4'h6 : 4'h2;
    // offset of one keeps its sign when the inputs are swapped
    assign lvl = (i_chop_swap ? 4'h8 - raw : raw) + 4'h1;
    assign o_mod_bit = acc_r[3];
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || i_mod_reset) begin
            acc_r <= 4'h0;
        end else begin
            acc_r <= acc_r + lvl - (o_mod_bit ? 4'h8 : 4'h0);
        end
    end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import scd_pkg::*;
    localparam int DB = 2;
    localparam int SEL_SETTLE = 0;
    localparam int SEL_VALID = 1;
    localparam int SEL_OVR = 2;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [FS_W-1:0] word = FS_OFF;
    logic s3 = 1'b0, ch = 1'b0, zl = 1'b0, nt = 1'b0, cc = 1'b0;
    logic ready = 1'b1, step = 1'b0, mbit, mrst, swap, valid, settling, ovr;
    logic [RES_W-1:0] data;
    int errors = 0;
    int n_compared = 0;
    int n;

    scd_sinc_chop_timing #(.DEC_BASE(DB)) i_dut (
        .i_sys_clk(clk), .i_nrst(nrst), .i_rate_select_word(word),
        .i_third_order_filter_select(s3), .i_chop_enable(ch),
        .i_zero_latency(zl), .i_sixty_hz_notch_enable(nt),
        .i_chan_change(cc), .i_mod_bit(mbit), .o_mod_reset(mrst),
        .o_chop_swap(swap), .o_result_valid(valid), .i_result_ready(ready),
        .o_result_data(data), .o_settling(settling), .o_overrun(ovr)
    );
    scd_mod_model i_mod (
        .i_sys_clk(clk), .i_nrst(nrst), .i_mod_reset(mrst),
        .i_chop_swap(swap), .i_step(step), .o_mod_bit(mbit)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // status pick by index, so waits need no by-reference argument
    function automatic logic pick(input int sel);
        case (sel)
            SEL_SETTLE: pick = settling;
            SEL_VALID: pick = valid;
            default: pick = ovr;
        endcase
    endfunction

    // bounded wait on a settled level, counting cycles
    task automatic wait_v(input int sel, input logic v, input int lim,
                          output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (pick(sel) !== v && k < lim);
        if (pick(sel) !== v) begin
            chk(1'b0, "timeout");
            end_of_test();
        end
    endtask

    task automatic run(input logic [FS_W-1:0] w, input logic [3:0] m,
                       input int settle, input int per);
        int a;
        int b;
        @(posedge clk);
        {s3, ch, zl, nt} <= m;
        word <= w;
        cc <= 1'b1;
        @(posedge clk);
        cc <= 1'b0;
        wait_v(SEL_SETTLE, 1'b1, 8, a);
        wait_v(SEL_SETTLE, 1'b0, settle + 8, a);
        chk(a >= settle - 2 && a <= settle + 2, "settling time");
        wait_v(SEL_VALID, 1'b1, 8, a);
        // an input step must not disturb the result cadence
        step <= ~step;
        for (int i = 0; i < 2; i++) begin
            wait_v(SEL_VALID, 1'b0, 4, a);
            wait_v(SEL_VALID, 1'b1, per + 4, b);
            chk(a + b == per, "result period");
        end
        $display("test done: word %0d mode %b", w, m);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        run(10'h003, 4'b1000, 18, 6);
        run(10'h003, 4'b1010, 18, 18);
        run(10'h001, 4'b0010, 8, 8);
        run(10'h002, 4'b0100, 32, 16);
        run(10'h003, 4'b1100, 36, 18);
        run(10'h002, 4'b0101, 32, 16);
        run(10'h001, 4'b1110, 12, 12);
        run(10'h001, 4'b0100, 16, 8);
        run(10'h3ff, 4'b0100, 16368, 8184);
        @(posedge clk);
        word <= FS_OFF;
        cc <= 1'b1;
        @(posedge clk);
        cc <= 1'b0;
        n = 0;
        repeat (100) begin
            @(negedge clk);
            n += int'(valid === 1'b1);
        end
        chk(n == 0, "result with rate word zero");
        $display("test done: rate word zero");
        @(posedge clk);
        {s3, ch, zl, nt} <= 4'b1000;
        word <= 10'h001;
        ready <= 1'b0;
        wait_v(SEL_OVR, 1'b1, 200, n);
        chk(valid === 1'b1, "queue head lost on overrun");
        @(posedge clk);
        word <= FS_OFF;
        ready <= 1'b1;
        n = 0;
        repeat (40) begin
            @(negedge clk);
            n += int'(valid === 1'b1);
        end
        chk(n >= FIFO_DEPTH, "queue drained short");
        chk(ovr === 1'b0, "overrun not cleared");
        $display("test done: overrun and drain");
        end_of_test();
    end
endmodule
